// ### pwdb_bridge_model.sv
// Bridge driver model: resolves gate levels and counts shoot-through
`timescale 1ns/1ps
module pwdb_bridge_model
  import pwdb_pkg::*;
(
  // Clock
  input  wire logic       hclk,
  // Pins from the block
  input  wire pwdb_pins_t pins,
  // Observations
  output logic [3:0]      gate,
  output int              shoot_cnt
);
  // Undriven gate inputs sit on the driver's pull-down
  always_comb gate = pins.lvl & pins.oe;

  // no leg fully on
  // Both switches of a leg on at once would short the supply
  initial shoot_cnt = 0;
  always @(posedge hclk) begin
    if ((gate[0] && gate[1]) || (gate[2] && gate[3]))
      shoot_cnt <= shoot_cnt + 1;
  end
endmodule

// ### pwdb_deadband.sv
// Dead-band delay stage for one pwm output line
`timescale 1ns/1ps
module pwdb_deadband
  import pwdb_pkg::*;
#(
  parameter int unsigned DELAY_W  = DB_DELAY_W,
  parameter int unsigned TCY_CLKS = CLK_PER_TCY
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Delay setting and level
  input  wire logic [DELAY_W-1:0] delay_count,
  input  wire logic               level_in,
  output wire logic               level_out
);

  localparam int unsigned CNT_W = DELAY_W + $clog2(TCY_CLKS) + 1;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             prev;
    logic             out;
  } pwdb_db_state_t;

  pwdb_db_state_t   st_reg;
  pwdb_db_state_t   st_next;
  logic [CNT_W-1:0] load_val;
  logic [CNT_W:0]   run_len_reg;
  logic [CNT_W-1:0] load_reg;

  // Refuse sizes the counter cannot hold
  generate
    if (DELAY_W < 1 || DELAY_W > 16 || TCY_CLKS < 1) begin : g_bad_param
      $error("pwdb_deadband: unsupported parameters");
    end
  endgenerate

  assign load_val = CNT_W'(32'(delay_count) * TCY_CLKS);

  // Edge handling: only the rising edge waits
  always_comb begin
    st_next      = st_reg;
    st_next.prev = level_in;
    if (!level_in) begin
      st_next.out = 1'b0;
      st_next.cnt = '0;
    end else if (!st_reg.prev) begin
      if (load_val == '0) begin
        st_next.out = 1'b1;
      end else begin
        st_next.cnt = load_val;
      end
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CNT_W'(1);
      if (st_reg.cnt == CNT_W'(1)) begin
        st_next.out = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.out;

  // Cycles the input has been high, for the checks only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_len_reg <= '0;
    end else if (!level_in) begin
      run_len_reg <= '0;
    end else if (run_len_reg != '1) begin
      run_len_reg <= run_len_reg + (CNT_W+1)'(1);
    end
  end

  // Count taken at the last rising input, for the checks only
  // A count rewritten mid-delay must not be judged against the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_reg <= '0;
    end else if (level_in && !st_reg.prev) begin
      load_reg <= load_val;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_db_delay;
    $rose(st_reg.out) |-> run_len_reg == {1'b0, load_reg} + (CNT_W+1)'(1);
  endproperty
  a_db_delay: assert property (p_db_delay) else $error("dead-band length wrong");

  property p_db_fall;
    !level_in |=> !st_reg.out;
  endproperty
  a_db_fall: assert property (p_db_fall) else $error("falling edge was delayed");

  property p_db_zero;
    level_in && !st_reg.prev && delay_count == '0 |=> st_reg.out;
  endproperty
  a_db_zero: assert property (p_db_zero) else $error("zero delay not immediate");

  c_db_edge: cover property (level_in && !st_reg.prev && delay_count != '0 ##[1:600] $rose(st_reg.out));

endmodule

// ### pwdb_pkg.sv
// Shared constants, register layouts and types for the pwm dead-band and shutdown block
package pwdb_pkg;

  // Register byte offsets on the AHB-Lite window
  localparam logic [7:0] OFS_DBCFG = 8'h00;
  localparam logic [7:0] OFS_SDCTL = 8'h04;
  localparam logic [7:0] OFS_MODE  = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;

  // Widths and counts
  localparam int unsigned DB_DELAY_W  = 7;
  localparam int unsigned CLK_PER_TCY = 4;
  localparam int unsigned IRQ_W       = 2;

  // Interrupt status bit positions
  localparam int unsigned IRQ_SHUTDOWN = 0;
  localparam int unsigned IRQ_RESTART  = 1;

  // Shutdown source bit positions inside the select field
  localparam int unsigned SRC_CMP1  = 0;
  localparam int unsigned SRC_CMP2  = 1;
  localparam int unsigned SRC_FAULT = 2;

  // Pin-pair shutdown state encoding, bit 1 set means float
  localparam logic [1:0] SDS_LOW   = 2'h0;
  localparam logic [1:0] SDS_HIGH  = 2'h1;
  localparam int unsigned SDS_FLOAT_BIT = 1;

  // Reset values
  localparam logic [7:0] DBCFG_RST = 8'h00;
  localparam logic [7:0] SDCTL_RST = 8'h00;
  localparam logic [2:0] MODE_RST  = 3'h0;
  localparam logic [1:0] IMASK_RST = 2'h0;

  // Output pin modes
  typedef enum logic [1:0] {
    PWDB_SINGLE,
    PWDB_FULL_FWD,
    PWDB_HALF,
    PWDB_FULL_REV
  } pwdb_mode_t;

  // Dead-band and restart configuration register
  typedef struct packed {
    logic                  auto_restart_enable;
    logic [DB_DELAY_W-1:0] deadband_delay_count;
  } pwdb_dbcfg_t;

  // Shutdown control register
  typedef struct packed {
    logic       shutdown_active_flag;
    logic [2:0] shutdown_source_select;
    logic [1:0] pair_ac_shutdown_state;
    logic [1:0] pair_bd_shutdown_state;
  } pwdb_sdctl_t;

  // Output mode register
  typedef struct packed {
    logic       enable;
    pwdb_mode_t mode;
  } pwdb_modereg_t;

  // Levels and enables of the four pins, index 0..3 is a, b, c, d
  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] oe;
  } pwdb_pins_t;

endpackage

// ### pwdb_top.sv
// Dead-band insertion and auto-shutdown for a four-pin enhanced pwm output stage
//
// Summary of operation
// - In half-bridge mode, inactive-to-active edges wait; active-to-inactive edges pass at once.
// - Dead-band equals the 7-bit delay count times one instruction cycle (four clocks).
// - Auto-shutdown works in every enhanced mode and covers every active pin.
// - Comparator one, comparator two, low fault pin, any mix, chosen by bits 6:4.
// - With no source selected, shutdown never starts; here a software write of 1 to bit 7 still starts it while restart is off.
// - A shutdown event forces pins to their shutdown states at once, without a clock.
// - Each pin pair independently drives high, drives low or floats in shutdown.
// - Hardware sets the shutdown flag, bit 7, and pins stay forced while set.
// - With restart enabled the flag clears when the cause ends; else software clears.
// - Flag set at a period start keeps pins forced for that whole period.
// - After the flag clears, normal output returns only at the next period start.
// - Software writes to the flag are ignored while a selected source is active.
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pwdb_top
  import pwdb_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output wire logic [31:0] hrdata,
  // Pwm generator
  input  wire logic        pwm_level,
  input  wire logic        pwm_period_start,
  // Shutdown sources
  input  wire logic        cmp1_out,
  input  wire logic        cmp2_out,
  input  wire logic        fault_input_n,
  // Output pins
  output wire logic        pwm_out_a,
  output wire logic        pwm_out_a_oe,
  output wire logic        pwm_out_b,
  output wire logic        pwm_out_b_oe,
  output wire logic        pwm_out_c,
  output wire logic        pwm_out_c_oe,
  output wire logic        pwm_out_d,
  output wire logic        pwm_out_d_oe,
  // Interrupt
  output wire logic        irq
);

  typedef struct packed {
    pwdb_dbcfg_t      dbcfg;
    pwdb_sdctl_t      sdctl;
    pwdb_modereg_t    modereg;
    logic [IRQ_W-1:0] imask;
    logic [IRQ_W-1:0] istat;
    logic             held;
    logic             wr_pend;
    logic             rd_pend;
    logic [7:0]       addr;
    logic             ready;
    logic [31:0]      rdata;
    pwdb_pins_t       pins;
    logic             irq;
  } pwdb_state_t;

  pwdb_state_t st_reg;
  pwdb_state_t st_next;
  logic        accept;
  logic        sd_wr;
  logic        src_hit;
  logic        sd_now;
  logic        flag_next;
  logic        held_next;
  logic [2:0]  src_vec;
  logic [1:0]  db_in;
  logic [1:0]  db_out;
  logic [7:0]  rd_val;
  logic [IRQ_W-1:0] irq_set;
  pwdb_pins_t  norm;
  pwdb_pins_t  pin;

  // Address phase taken only with hready high
  assign accept = hsel && hready && htrans[1];
  assign sd_wr  = st_reg.wr_pend && (st_reg.addr == OFS_SDCTL);

  assign src_vec[SRC_CMP1]  = cmp1_out;
  assign src_vec[SRC_CMP2]  = cmp2_out;
  assign src_vec[SRC_FAULT] = !fault_input_n;
  assign src_hit = st_reg.modereg.enable && |(st_reg.sdctl.shutdown_source_select & src_vec);

  assign sd_now = st_reg.modereg.enable && (src_hit || st_reg.sdctl.shutdown_active_flag || st_reg.held);

  // Flag update, hardware set beats any clear
  always_comb begin
    flag_next = st_reg.sdctl.shutdown_active_flag;
    if (sd_wr && !src_hit) begin
      flag_next = hwdata[7];
    end
    if (st_reg.dbcfg.auto_restart_enable && !src_hit) begin
      flag_next = 1'b0;
    end
    if (src_hit) begin
      flag_next = 1'b1;
    end
  end

  always_comb begin
    if (st_reg.sdctl.shutdown_active_flag) begin
      held_next = 1'b1;
    end else if (pwm_period_start) begin
      held_next = 1'b0;
    end else begin
      held_next = st_reg.held;
    end
  end

  // Dead-band stages feed only the half-bridge pair
  assign db_in[0] = (st_reg.modereg.mode == PWDB_HALF) && pwm_level;
  assign db_in[1] = (st_reg.modereg.mode == PWDB_HALF) && !pwm_level;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_db
      pwdb_deadband #(
        .DELAY_W  (DB_DELAY_W),
        .TCY_CLKS (CLK_PER_TCY)
      ) u_db (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .delay_count (st_reg.dbcfg.deadband_delay_count),
        .level_in    (db_in[g]),
        .level_out   (db_out[g])
      );
    end
  endgenerate

  // Normal pin levels per mode; unused pins are not driven
  always_comb begin
    norm = '0;
    unique case (st_reg.modereg.mode)
      PWDB_SINGLE: begin
        norm.lvl = {3'h0, pwm_level};
        norm.oe  = 4'h1;
      end
      PWDB_FULL_FWD: begin
        norm.lvl = {pwm_level, 2'h0, 1'b1};
        norm.oe  = 4'hF;
      end
      PWDB_HALF: begin
        norm.lvl = {2'h0, db_out};
        norm.oe  = 4'h3;
      end
      PWDB_FULL_REV: begin
        norm.lvl = {1'b0, 1'b1, pwm_level, 1'b0};
        norm.oe  = 4'hF;
      end
    endcase
    if (!st_reg.modereg.enable) begin
      norm = '0;
    end
  end

  // Register read mux
  always_comb begin
    rd_val = 8'h00;
    unique case (st_reg.addr)
      OFS_DBCFG: rd_val = st_reg.dbcfg;
      OFS_SDCTL: rd_val = st_reg.sdctl;
      OFS_MODE:  rd_val = {5'h00, st_reg.modereg};
      OFS_ISTAT: rd_val = {6'h00, st_reg.istat};
      OFS_IMASK: rd_val = {6'h00, st_reg.imask};
      OFS_STAT:  rd_val = {3'h0, st_reg.held, sd_now, src_vec};
      default:   rd_val = 8'h00;
    endcase
  end

  // Events: flag rising, and outputs returning at a period start
  assign irq_set[IRQ_SHUTDOWN] = flag_next && !st_reg.sdctl.shutdown_active_flag;
  assign irq_set[IRQ_RESTART]  = st_reg.held && !held_next;

  // Next state of the whole block
  always_comb begin
    st_next         = st_reg;
    st_next.wr_pend = accept && hwrite;
    st_next.rd_pend = accept && !hwrite;
    st_next.ready   = !(accept && !hwrite);
    if (accept) begin
      st_next.addr = haddr[7:0];
    end
    // Read data one wait state later, so a write just before is seen
    if (st_reg.rd_pend) begin
      st_next.rdata = {24'h000000, rd_val};
    end
    // Write data phase; unmapped offsets are ignored
    if (st_reg.wr_pend) begin
      unique case (st_reg.addr)
        OFS_DBCFG: st_next.dbcfg = pwdb_dbcfg_t'(hwdata[7:0]);
        OFS_SDCTL: begin
          st_next.sdctl.shutdown_source_select = hwdata[6:4];
          st_next.sdctl.pair_ac_shutdown_state = hwdata[3:2];
          st_next.sdctl.pair_bd_shutdown_state = hwdata[1:0];
        end
        OFS_MODE:  st_next.modereg = pwdb_modereg_t'(hwdata[2:0]);
        OFS_IMASK: st_next.imask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    st_next.sdctl.shutdown_active_flag = flag_next;
    st_next.held                       = held_next;
    // Write-one-to-clear, a new event wins over the clear
    st_next.istat = st_reg.istat | irq_set;
    if (st_reg.wr_pend && st_reg.addr == OFS_ISTAT) begin
      st_next.istat = (st_reg.istat & ~hwdata[IRQ_W-1:0]) | irq_set;
    end
    st_next.irq  = |(st_next.istat & st_next.imask);
    st_next.pins = norm;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg         <= '0;
      st_reg.dbcfg   <= pwdb_dbcfg_t'(DBCFG_RST);
      st_reg.sdctl   <= pwdb_sdctl_t'(SDCTL_RST);
      st_reg.modereg <= pwdb_modereg_t'(MODE_RST);
      st_reg.imask   <= IMASK_RST;
      st_reg.ready   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // combinational override, no clock edge in the path
  // only pins active in the mode
  generate
    for (genvar p = 0; p < 4; p++) begin : g_pin
      logic [1:0] sds;
      // pair a/c even, pair b/d odd
      assign sds = (p % 2 == 0) ? st_reg.sdctl.pair_ac_shutdown_state : st_reg.sdctl.pair_bd_shutdown_state;
      assign pin.lvl[p] = sd_now ? (sds == SDS_HIGH) : st_reg.pins.lvl[p];
      assign pin.oe[p]  = st_reg.pins.oe[p] && !(sd_now && sds[SDS_FLOAT_BIT]);
    end
  endgenerate

  assign pwm_out_a    = pin.lvl[0];
  assign pwm_out_b    = pin.lvl[1];
  assign pwm_out_c    = pin.lvl[2];
  assign pwm_out_d    = pin.lvl[3];
  assign pwm_out_a_oe = pin.oe[0];
  assign pwm_out_b_oe = pin.oe[1];
  assign pwm_out_c_oe = pin.oe[2];
  assign pwm_out_d_oe = pin.oe[3];

  // Bus answers; errors are never signalled
  assign hreadyout = st_reg.ready;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;
  assign irq       = st_reg.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sd_pins;
    src_hit |-> (pwm_out_a_oe == (st_reg.pins.oe[0] && !st_reg.sdctl.pair_ac_shutdown_state[1]))
      && (pwm_out_b == (st_reg.sdctl.pair_bd_shutdown_state == SDS_HIGH));
  endproperty
  a_sd_pins: assert property (p_sd_pins) else $error("pins not forced on event");

  property p_flag_set;
    src_hit |=> st_reg.sdctl.shutdown_active_flag ##1 st_reg.held;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag or hold not set");

  property p_no_src;
    st_reg.sdctl.shutdown_source_select == 3'h0 && !st_reg.sdctl.shutdown_active_flag && !sd_wr
      |=> !st_reg.sdctl.shutdown_active_flag;
  endproperty
  a_no_src: assert property (p_no_src) else $error("shutdown with no source");

  property p_restart;
    st_reg.sdctl.shutdown_active_flag && st_reg.dbcfg.auto_restart_enable && !src_hit
      |=> !st_reg.sdctl.shutdown_active_flag;
  endproperty
  a_restart: assert property (p_restart) else $error("auto restart missed");

  property p_manual;
    st_reg.sdctl.shutdown_active_flag && !st_reg.dbcfg.auto_restart_enable && !sd_wr
      |=> st_reg.sdctl.shutdown_active_flag;
  endproperty
  a_manual: assert property (p_manual) else $error("flag cleared without software");

  property p_wr_block;
    sd_wr && src_hit |=> st_reg.sdctl.shutdown_active_flag;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("flag write took effect");

  property p_hold_period;
    pwm_period_start && st_reg.sdctl.shutdown_active_flag && st_reg.modereg.enable |=> sd_now;
  endproperty
  a_hold_period: assert property (p_hold_period) else $error("released in held period");

  property p_resume;
    st_reg.held && !pwm_period_start |=> st_reg.held;
  endproperty
  a_resume: assert property (p_resume) else $error("release off period start");

  property p_irq;
    irq == |(st_reg.istat & st_reg.imask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");

  c_shutdown: cover property (src_hit ##1 st_reg.sdctl.shutdown_active_flag);
  c_restart:  cover property (st_reg.held ##1 !st_reg.held);
  c_read:     cover property (st_reg.rd_pend ##1 st_reg.ready);
  c_half:     cover property (st_reg.modereg.enable && st_reg.modereg.mode == PWDB_HALF && $rose(db_out[0]));

endmodule

// ### test_pwm_deadband_autoshutdown.sv
// Self-checking bench for the dead-band and auto-shutdown block
`timescale 1ns/1ps
module test_pwm_deadband_autoshutdown;
  import pwdb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        pwm_level, pwm_period_start, cmp1_out, cmp2_out, fault_input_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [3:0]  lvl, oe, gate;
  pwdb_pins_t  pins;
  int          n_mismatch, checks, shoot_cnt;

  // Clock at 50 MHz
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  assign pins = {lvl, oe};

  // Block under test, single slave so hready is its own hreadyout
  pwdb_top i_pwdb_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_level(pwm_level),
    .pwm_period_start(pwm_period_start), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .fault_input_n(fault_input_n), .pwm_out_a(lvl[0]), .pwm_out_a_oe(oe[0]),
    .pwm_out_b(lvl[1]), .pwm_out_b_oe(oe[1]), .pwm_out_c(lvl[2]), .pwm_out_c_oe(oe[2]),
    .pwm_out_d(lvl[3]), .pwm_out_d_oe(oe[3]), .irq(irq)
  );

  // Far side of the pins
  pwdb_bridge_model i_pwdb_bridge_model (.hclk(hclk), .pins(pins), .gate(gate), .shoot_cnt(shoot_cnt));

  // Comparison of any result
  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Bounded wait, a hung slave counts as a mismatch
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) chk_w("hreadyout", 1, 0);
  endtask

  // One single AHB transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // Pins held in the programmed shutdown states, pair a/c and pair b/d
  task automatic chk_pins(input logic [1:0] ac, input logic [1:0] bd);
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[0] ? bd : ac;
      chk_w("pin_oe", !s[SDS_FLOAT_BIT], oe[i]);
      chk_w("pin_lvl", s == SDS_HIGH, lvl[i] & oe[i]);
    end
  endtask

  task automatic pulse_period;
    pwm_period_start <= 1'b1;
    cyc(1);
    pwm_period_start <= 1'b0;
  endtask

  // Reset values, unmapped place, write and read back
  task automatic t_regs;
    logic [7:0] a[5] = '{OFS_DBCFG, OFS_SDCTL, OFS_MODE, OFS_ISTAT, OFS_IMASK};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 0);
      chk_w("reset_value", 0, rd);
    end
    bus(1'b1, 8'h18, 32'h000000FF);
    bus(1'b0, 8'h18, 0);
    chk_w("unmapped", 0, rd);
    bus(1'b1, OFS_DBCFG, 32'h000000FF);
    bus(1'b0, OFS_DBCFG, 0);
    chk_w("dbcfg", 32'h000000FF, rd);
  endtask

  // Half-bridge: rising edges wait 4 clocks per count, falling edges do not
  task automatic t_dead;
    int d[3] = '{0, 1, 127};
    int ra, fb, ra0, n;
    bus(1'b1, OFS_MODE, 32'h00000006);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, OFS_DBCFG, d[k]);
      pwm_level <= 1'b0;
      cyc(600);
      pwm_level <= 1'b1;
      n = 0;
      fb = -1;
      do begin
        @(posedge hclk);
        #1 n++;
        if (fb < 0 && lvl[1] === 1'b0) fb = n;
      end while (lvl[0] !== 1'b1 && n < 700);
      ra = n;
      ra0 = (k == 0) ? ra : ra0;
      chk_w("rise_delay", 4 * d[k], ra - ra0);
      chk_w("fall_delay", 2, fb);
      chk_w("zero_count", 2, ra0);
      @(posedge hclk);
    end
    bus(1'b1, OFS_DBCFG, 0);
  endtask

  // Each source alone, with each pair state, restart off
  task automatic t_src;
    logic [1:0] ac[3] = '{2'h1, 2'h0, 2'h2};
    logic [1:0] bd[3] = '{2'h0, 2'h3, 2'h1};
    bus(1'b1, OFS_MODE, 32'h00000005);
    pwm_level <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      bus(1'b1, OFS_SDCTL, {24'h0, 1'b0, 3'(1 << i), ac[i], bd[i]});
      cmp1_out      <= i == 0;
      cmp2_out      <= i == 1;
      fault_input_n <= i != 2;
      #1 chk_pins(ac[i], bd[i]);
      cyc(3);
      #1 chk_w("irq_masked", 0, irq);
      cyc(1);
      bus(1'b0, OFS_SDCTL, 0);
      chk_w("flag_set", 1, rd[7]);
      cmp1_out      <= 1'b0;
      cmp2_out      <= 1'b0;
      fault_input_n <= 1'b1;
      cyc(3);
      bus(1'b0, OFS_SDCTL, 0);
      chk_w("flag_kept", 1, rd[7]);
      bus(1'b1, OFS_SDCTL, {24'h0, 1'b0, 3'(1 << i), ac[i], bd[i]});
      bus(1'b0, OFS_SDCTL, 0);
      chk_w("flag_sw_clear", 0, rd[7]);
      #1 chk_pins(ac[i], bd[i]);
      cyc(1);
      pulse_period();
      cyc(3);
      #1 chk_w("normal_pins", 8'h9F, {lvl, oe});
    end
  endtask

  // No source selected: all sources trip, nothing happens
  task automatic t_none;
    cyc(1);
    bus(1'b1, OFS_SDCTL, 0);
    cmp1_out      <= 1'b1;
    cmp2_out      <= 1'b1;
    fault_input_n <= 1'b0;
    cyc(3);
    #1 chk_w("pins_unforced", 8'h9F, {lvl, oe});
    cyc(1);
    bus(1'b0, OFS_SDCTL, 0);
    chk_w("flag_idle", 0, rd);
    cmp1_out      <= 1'b0;
    cmp2_out      <= 1'b0;
    fault_input_n <= 1'b1;
  endtask

  // Single and full-reverse pin patterns, raw source status
  task automatic t_modes;
    bus(1'b1, OFS_MODE, 32'h00000004);
    cyc(1);
    #1 chk_w("single_pins", 8'h11, {lvl, oe});
    cyc(1);
    bus(1'b1, OFS_MODE, 32'h00000007);
    pwm_level <= 1'b0;
    cmp1_out  <= 1'b1;
    cyc(2);
    #1 chk_w("rev_pins", 8'h4F, {lvl, oe});
    cyc(1);
    bus(1'b0, OFS_STAT, 0);
    chk_w("stat", 32'h00000001, rd);
    cmp1_out  <= 1'b0;
    pwm_level <= 1'b1;
  endtask

  // Auto restart in half mode, refused flag write, interrupt
  task automatic t_restart;
    // Old events cleared first, so the interrupt reflects this shutdown
    bus(1'b1, OFS_ISTAT, 3);
    bus(1'b1, OFS_IMASK, 3);
    bus(1'b1, OFS_DBCFG, 32'h00000080);
    bus(1'b1, OFS_MODE, 32'h00000006);
    bus(1'b1, OFS_SDCTL, 32'h00000020);
    cmp2_out <= 1'b1;
    cyc(3);
    #1 chk_w("irq", 1, irq);
    cyc(1);
    bus(1'b1, OFS_SDCTL, 32'h00000020);
    bus(1'b0, OFS_SDCTL, 0);
    chk_w("flag_locked", 1, rd[7]);
    pulse_period();
    cyc(1);
    cmp2_out <= 1'b0;
    #1 chk_w("pin_a_forced", 2'b01, {lvl[0], oe[0]});
    cyc(3);
    bus(1'b0, OFS_SDCTL, 0);
    chk_w("flag_auto_clear", 0, rd[7]);
    #1 chk_w("pin_a_still", 2'b01, {lvl[0], oe[0]});
    cyc(1);
    pulse_period();
    cyc(4);
    #1 chk_w("pin_a_back", 2'b11, {lvl[0], oe[0]});
    cyc(1);
    bus(1'b0, OFS_ISTAT, 0);
    chk_w("istat", 3, rd);
    bus(1'b1, OFS_ISTAT, 3);
    bus(1'b0, OFS_ISTAT, 0);
    chk_w("istat_clear", 0, rd);
    cyc(1);
    #1 chk_w("irq_low", 0, irq);
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, pwm_level, pwm_period_start, cmp1_out, cmp2_out} = 0;
    {haddr, hwdata, htrans} = 0;
    fault_input_n = 1'b1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_dead();
    t_src();
    t_none();
    t_modes();
    t_restart();
    chk_w("shoot_through", 0, shoot_cnt);
    final_report();
  end

  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end
endmodule
